// [logic/fom_pkg.sv]
package fom_pkg;
// Behaviour
// R1 - fault A mask bits add inputs 1-8 and 9-12 to its set
// R2 - fault A upper bits 4,5,6 enable over, under, early-warning
// R3 - fault A bit 7: zero active-low, one active-high
// R4 - fault B takes inputs 1-8 and 9-12 from its own masks
// R5 - fault B upper bits 4,5,6 enable over, under, early-warning
// R6 - fault B bit 7 clear active-low, set active-high
// R7 - any one violating selected input asserts the fault output
// R8 - any-fault pins go low on any violation of any input
// R9 - power-up fault pin asserts, kills enables, stores the record; this block drives no enable outputs, only the pin, the flag and the log pulse
// R10 - margin pin levels pick raise, lower or normal DAC bank
// R11 - differing margin selects close DAC switches, else enables rule
// R12 - margin on when margin pin low or control bit 1 set
// R13 - margin freezes both fault outputs, any-fault and reset
// R14 - margin ignores violations and writes no fault log entry
// R15 - board drives margin low before moving supplies, high after
// R16 - manual reset low holds the reset output asserted
// R17 - after manual reset rises, reset stays low for the timeout
// R18 - pin six code 110 gives open-drain active-low watchdog out
// R19 - pin five code 111 makes it the watchdog input
// R20 - empty set or no enabled type leaves output deasserted
// R21 - margin, margin select and manual reset pins pass two flops

  localparam int MON_N = 12;
  localparam int GPIO_N = 6;
  localparam int IDX_W = 10;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_FA_LO = 10'h015;
  localparam logic [9:0] IDX_FA_HI = 10'h016;
  localparam logic [9:0] IDX_FB_LO = 10'h017;
  localparam logic [9:0] IDX_FB_HI = 10'h018;
  localparam logic [9:0] IDX_CFG0 = 10'h01C;
  localparam logic [9:0] IDX_CFG1 = 10'h01D;
  localparam logic [9:0] IDX_CFG2 = 10'h01E;
  localparam logic [9:0] IDX_CTRL = 10'h04D;
  localparam logic [9:0] IDX_DEN_LO = 10'h030;
  localparam logic [9:0] IDX_DEN_HI = 10'h031;
  localparam logic [9:0] IDX_STAT = 10'h032;
  // field positions
  localparam int B_OV = 4;
  localparam int B_UV = 5;
  localparam int B_EW = 6;
  localparam int B_POL = 7;
  localparam int B_MARGIN = 1;
  localparam int B_PU_CLR = 0;
  localparam int G1_LSB = 0;
  localparam int G2_LSB = 3;
  localparam int G3_LSB = 6;
  localparam int G4_LSB = 1;
  localparam int G5_LSB = 4;
  localparam int G6_BIT = 7;
  localparam logic [7:0] REG_RST = 8'h00;
  // reset stretch timing at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int RST_TIMEOUT_US = 25;
  localparam int RST_TIMEOUT_CYC = RST_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    M_BASE = 3'h0, M_AF_PP = 3'h3, M_AF_OD = 3'h4,
    M_WDO = 3'h6, M_SPECIAL = 3'h7
  } fom_mode_t;
  typedef enum logic [1:0] {
    BK_NORMAL = 2'h0, BK_RAISE = 2'h1, BK_LOWER = 2'h2
  } fom_bank_t;
  typedef enum logic [1:0] {
    RS_IDLE = 2'h0, RS_HOLD = 2'h1, RS_STRETCH = 2'h3
  } fom_rst_t;
endpackage

// [logic/fom_pin_logic.sv]
`timescale 1ns/1ps
module fom_pin_logic
  import fom_pkg::*;
#(
  parameter int RST_CYC = RST_TIMEOUT_CYC,
  parameter int AW      = 12
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // threshold violations from the comparators
  input  wire logic [MON_N-1:0]  ov_viol,
  input  wire logic [MON_N-1:0]  uv_viol,
  input  wire logic [MON_N-1:0]  ew_viol,
  // sequencer and watchdog
  input  wire logic              pu_fault_evt,
  input  wire logic              wd_expired,
  // configurable pins
  input  wire logic [GPIO_N-1:0] gpio_in,
  output logic      [GPIO_N-1:0] gpio_out,
  output logic      [GPIO_N-1:0] gpio_oe,
  // block status
  output logic                   fault_out_a,
  output logic                   fault_out_b,
  output logic                   any_fault_n,
  output logic                   reset_out_n,
  output logic                   powerup_fault_flag,
  output logic                   fault_log_store,
  output logic                   margin_active,
  output logic      [1:0]        dac_bank_sel,
  output logic      [MON_N-1:0]  trim_dac_output,
  output logic                   wd_kick_level
);

  localparam int CW = $clog2(RST_CYC + 1);

  if (RST_CYC < 1 || AW < IDX_W + 2) begin : g_bad
    $error("fom_pin_logic: bad parameter");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic fault_lvl(input logic [7:0] lo,
                                     input logic [7:0] hi,
                                     input logic [MON_N-1:0] ov,
                                     input logic [MON_N-1:0] uv,
                                     input logic [MON_N-1:0] ew);
    logic [MON_N-1:0] sel;
    logic [MON_N-1:0] hit;
    sel = {hi[3:0], lo};
    hit = (ov & {MON_N{hi[B_OV]}}) | (uv & {MON_N{hi[B_UV]}})
        | (ew & {MON_N{hi[B_EW]}});
    return (|(sel & hit)) ~^ hi[B_POL];
  endfunction

  // returns {out, oe}
  function automatic logic [1:0] drive(input logic od,
                                       input logic lvl);
    return od ? {1'b0, ~lvl} : {lvl, 1'b1};
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [GPIO_N-1:0] gs1_r;
  logic [GPIO_N-1:0] gs2_r;

  // R21 two-flop sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gs1_r <= '1;
      gs2_r <= '1;
    end else begin
      gs1_r <= gpio_in;
      gs2_r <= gs1_r;
    end
  end

  // ----------------------------------------------------------------
  // registers and apb
  // ----------------------------------------------------------------
  logic [7:0]       fa_lo_r, fa_hi_r, fb_lo_r, fb_hi_r;
  logic [7:0]       cfg0_r, cfg1_r, ctrl_r, den_lo_r;
  logic [1:0]       cfg2_r;
  logic [3:0]       den_hi_r;
  logic [7:0]       fa_lo_nxt, fa_hi_nxt, fb_lo_nxt, fb_hi_nxt;
  logic [7:0]       cfg0_nxt, cfg1_nxt, ctrl_nxt, den_lo_nxt;
  logic [1:0]       cfg2_nxt;
  logic [3:0]       den_hi_nxt;
  logic [31:0]      prdata_r, prdata_nxt;
  logic             pready_r, pready_nxt;
  logic             pslverr_r, pslverr_nxt;
  logic [IDX_W-1:0] idx;
  logic             wr_en, pu_clr;
  logic [7:0]       rd_byte, stat_byte;
  logic             mapped;

  assign idx = paddr[IDX_W+1:2];
  assign wr_en = psel && penable && pready_r && pwrite;
  assign pu_clr = wr_en && idx == IDX_STAT && pwdata[B_PU_CLR];

  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      IDX_FA_LO: rd_byte = fa_lo_r;
      IDX_FA_HI: rd_byte = fa_hi_r;
      IDX_FB_LO: rd_byte = fb_lo_r;
      IDX_FB_HI: rd_byte = fb_hi_r;
      IDX_CFG0: rd_byte = cfg0_r;
      IDX_CFG1: rd_byte = cfg1_r;
      IDX_CFG2: rd_byte = {6'h00, cfg2_r};
      IDX_CTRL: rd_byte = ctrl_r;
      IDX_DEN_LO: rd_byte = den_lo_r;
      IDX_DEN_HI: rd_byte = {4'h0, den_hi_r};
      IDX_STAT: rd_byte = stat_byte;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    fa_lo_nxt = fa_lo_r;
    fa_hi_nxt = fa_hi_r;
    fb_lo_nxt = fb_lo_r;
    fb_hi_nxt = fb_hi_r;
    cfg0_nxt = cfg0_r;
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    ctrl_nxt = ctrl_r;
    den_lo_nxt = den_lo_r;
    den_hi_nxt = den_hi_r;
    // one wait state, answer on second access cycle
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = pready_nxt && !mapped;
    prdata_nxt = prdata_r;
    if (pready_nxt && !pwrite) begin
      prdata_nxt = {24'h000000, rd_byte};
    end
    if (wr_en) begin
      case (idx)
        IDX_FA_LO: fa_lo_nxt = pwdata[7:0];
        IDX_FA_HI: fa_hi_nxt = pwdata[7:0];
        IDX_FB_LO: fb_lo_nxt = pwdata[7:0];
        IDX_FB_HI: fb_hi_nxt = pwdata[7:0];
        IDX_CFG0: cfg0_nxt = pwdata[7:0];
        IDX_CFG1: cfg1_nxt = pwdata[7:0];
        IDX_CFG2: cfg2_nxt = pwdata[1:0];
        IDX_CTRL: ctrl_nxt = pwdata[7:0];
        IDX_DEN_LO: den_lo_nxt = pwdata[7:0];
        IDX_DEN_HI: den_hi_nxt = pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_lo_r <= REG_RST;
      fa_hi_r <= REG_RST;
      fb_lo_r <= REG_RST;
      fb_hi_r <= REG_RST;
      cfg0_r <= REG_RST;
      cfg1_r <= REG_RST;
      cfg2_r <= 2'h0;
      ctrl_r <= REG_RST;
      den_lo_r <= REG_RST;
      den_hi_r <= 4'h0;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      fa_lo_r <= fa_lo_nxt;
      fa_hi_r <= fa_hi_nxt;
      fb_lo_r <= fb_lo_nxt;
      fb_hi_r <= fb_hi_nxt;
      cfg0_r <= cfg0_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      ctrl_r <= ctrl_nxt;
      den_lo_r <= den_lo_nxt;
      den_hi_r <= den_hi_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin modes and margin
  // ----------------------------------------------------------------
  logic [2:0] m1, m2, m3, m4, m5, m6;
  logic       margin_c, up_lvl, dn_lvl, mr_low, sw_closed;
  fom_bank_t  bank_c;

  assign m1 = cfg0_r[G1_LSB +: 3];
  assign m2 = cfg0_r[G2_LSB +: 3];
  assign m3 = {cfg1_r[0], cfg0_r[G3_LSB +: 2]};
  assign m4 = cfg1_r[G4_LSB +: 3];
  assign m5 = cfg1_r[G5_LSB +: 3];
  assign m6 = {cfg2_r, cfg1_r[G6_BIT]};

  // R12 margin enable
  assign margin_c = (m6 == M_BASE && !gs2_r[5]) || ctrl_r[B_MARGIN];
  assign up_lvl = (m2 == M_SPECIAL) ? gs2_r[1] : 1'b1;
  assign dn_lvl = (m3 == M_SPECIAL) ? gs2_r[2] : 1'b1;
  assign mr_low = (m4 == M_SPECIAL) && !gs2_r[3];
  // R11 switches close on differing selects
  assign sw_closed = up_lvl ^ dn_lvl;

  // R10 bank choice
  always_comb begin
    bank_c = BK_NORMAL;
    if (!up_lvl && dn_lvl) begin
      bank_c = BK_RAISE;
    end else if (up_lvl && !dn_lvl) begin
      bank_c = BK_LOWER;
    end
  end

  // ----------------------------------------------------------------
  // manual reset stretch
  // ----------------------------------------------------------------
  fom_rst_t rs_r, rs_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  // R17 timeout after release
  always_comb begin
    rs_nxt = rs_r;
    cnt_nxt = cnt_r;
    case (rs_r)
      RS_IDLE: begin
        if (mr_low) begin
          rs_nxt = RS_HOLD;
        end
      end
      RS_HOLD: begin
        cnt_nxt = '0;
        if (!mr_low) begin
          rs_nxt = RS_STRETCH;
        end
      end
      RS_STRETCH: begin
        cnt_nxt = cnt_r + 1'b1;
        if (mr_low) begin
          rs_nxt = RS_HOLD;
        end else if (cnt_r == CW'(RST_CYC - 1)) begin
          rs_nxt = RS_IDLE;
        end
      end
      default: rs_nxt = RS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_r <= RS_IDLE;
      cnt_r <= '0;
    end else begin
      rs_r <= rs_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // fault and pin outputs
  // ----------------------------------------------------------------
  logic              fa_r, fb_r, af_r, rst_r, pu_r, log_r, mg_r, wdk_r;
  logic              fa_nxt, fb_nxt, af_nxt, rst_nxt, pu_nxt, log_nxt;
  logic [1:0]        bank_r;
  logic [MON_N-1:0]  sw_r, sw_nxt;
  logic [GPIO_N-1:0] go_r, goe_r, go_nxt, goe_nxt;
  logic              pu_set;
  logic [1:0]        d;

  // R14 no logging while margin
  assign pu_set = pu_fault_evt && m6 == M_SPECIAL && !margin_c;
  assign stat_byte = {bank_r, rst_r, af_r, fb_r, fa_r, mg_r, pu_r};

  always_comb begin
    // R13 freeze while margin
    fa_nxt = fa_r;
    fb_nxt = fb_r;
    af_nxt = af_r;
    rst_nxt = rst_r;
    if (!margin_c) begin
      // R1 R2 R3 R7 R20 fault A level
      fa_nxt = fault_lvl(fa_lo_r, fa_hi_r, ov_viol, uv_viol, ew_viol);
      // R4 R5 R6 fault B level
      fb_nxt = fault_lvl(fb_lo_r, fb_hi_r, ov_viol, uv_viol, ew_viol);
      // R8 any-fault low
      af_nxt = ~|(ov_viol | uv_viol | ew_viol);
      // R16 manual reset drive
      rst_nxt = !(mr_low || rs_r != RS_IDLE);
    end
    // R9 power-up flag, set wins
    pu_nxt = pu_set || (pu_r && !pu_clr);
    log_nxt = pu_set;
    sw_nxt = sw_closed ? '1 : {den_hi_r, den_lo_r};
  end

  always_comb begin
    go_nxt = '0;
    goe_nxt = '0;
    d = 2'b00;
    for (int i = 0; i < 4; i++) begin
      d = drive(cfg_mode(i) == M_AF_OD, af_nxt);
      if (cfg_mode(i) == M_AF_PP || cfg_mode(i) == M_AF_OD) begin
        go_nxt[i] = d[1];
        goe_nxt[i] = d[0];
      end
    end
    if (m5 == M_AF_PP || m5 == M_AF_OD) begin
      d = drive(m5 == M_AF_OD, fa_nxt);
      go_nxt[4] = d[1];
      goe_nxt[4] = d[0];
    end
    case (m6)
      M_AF_PP, M_AF_OD: begin
        d = drive(m6 == M_AF_OD, fb_nxt);
        go_nxt[5] = d[1];
        goe_nxt[5] = d[0];
      end
      // R18 watchdog out, open-drain low
      M_WDO: goe_nxt[5] = wd_expired;
      // R9 power-up fault pin, open-drain low
      M_SPECIAL: goe_nxt[5] = pu_nxt;
      default: ;
    endcase
  end

  function automatic logic [2:0] cfg_mode(input int i);
    case (i)
      0: return m1;
      1: return m2;
      2: return m3;
      default: return m4;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_r <= 1'b1;
      fb_r <= 1'b1;
      af_r <= 1'b1;
      rst_r <= 1'b1;
      pu_r <= 1'b0;
      log_r <= 1'b0;
      mg_r <= 1'b0;
      wdk_r <= 1'b0;
      bank_r <= BK_NORMAL;
      sw_r <= '0;
      go_r <= '0;
      goe_r <= '0;
    end else begin
      fa_r <= fa_nxt;
      fb_r <= fb_nxt;
      af_r <= af_nxt;
      rst_r <= rst_nxt;
      pu_r <= pu_nxt;
      log_r <= log_nxt;
      mg_r <= margin_c;
      // R19 watchdog input pin
      wdk_r <= (m5 == M_SPECIAL) && gs2_r[4];
      bank_r <= bank_c;
      sw_r <= sw_nxt;
      go_r <= go_nxt;
      goe_r <= goe_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign gpio_out = go_r;
  assign gpio_oe = goe_r;
  assign fault_out_a = fa_r;
  assign fault_out_b = fb_r;
  assign any_fault_n = af_r;
  assign reset_out_n = rst_r;
  assign powerup_fault_flag = pu_r;
  assign fault_log_store = log_r;
  assign margin_active = mg_r;
  assign dac_bank_sel = bank_r;
  assign trim_dac_output = sw_r;
  assign wd_kick_level = wdk_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fault_a_ov_a: assert property ( // R1
    (!margin_c && fa_hi_r[B_POL] && fa_hi_r[B_OV]
     && |({fa_hi_r[3:0], fa_lo_r} & ov_viol)) |=> fault_out_a)
    else $error("fault A missed an overvoltage");
  fault_b_uv_a: assert property ( // R5
    (!margin_c && !fb_hi_r[B_POL] && fb_hi_r[B_UV]
     && |({fb_hi_r[3:0], fb_lo_r} & uv_viol)) |=> !fault_out_b)
    else $error("fault B missed an undervoltage");
  idle_level_a: assert property ( // R20
    (!margin_c && fa_hi_r[6:4] == 3'h0)
    |=> fault_out_a == $past(!fa_hi_r[B_POL]))
    else $error("fault A not at its idle level");
  any_fault_a: assert property ( // R8
    (!margin_c && |(ov_viol | uv_viol | ew_viol)) |=> !any_fault_n)
    else $error("any-fault did not assert");
  freeze_a: assert property ( // R13
    margin_c |=> $stable(fault_out_a) && $stable(fault_out_b)
                 && $stable(any_fault_n) && $stable(reset_out_n))
    else $error("outputs moved during margin");
  no_log_a: assert property ( // R14
    (margin_c && $past(margin_c)) |-> !fault_log_store || $past(!margin_c, 2))
    else $error("fault logged during margin");
  bank_sel_a: assert property ( // R10
    (m2 == M_SPECIAL && m3 == M_SPECIAL && !gs2_r[1] && gs2_r[2])
    |=> dac_bank_sel == BK_RAISE)
    else $error("raise bank not chosen");
  switch_a: assert property ( // R11
    (up_lvl != dn_lvl) |=> &trim_dac_output)
    else $error("dac switches not closed");
  mr_hold_a: assert property ( // R16
    (!margin_c && mr_low) |=> !reset_out_n)
    else $error("reset not asserted by manual reset");
  mr_stretch_a: assert property ( // R17
    (rs_r == RS_HOLD && !mr_low && !margin_c) ##1 !margin_c
    |=> !reset_out_n)
    else $error("reset released without timeout");
  wdo_a: assert property ( // R18
    (m6 == M_WDO) |=> !gpio_out[5] && gpio_oe[5] == $past(wd_expired))
    else $error("watchdog output drive wrong");

endmodule

// [verification/fom_board_model.sv]
`timescale 1ns/1ps
module fom_board_model
  import fom_pkg::*;
(
  // board pin commands, levels
  input  wire logic              margin_raise_sel_n,
  input  wire logic              margin_lower_sel_n,
  input  wire logic              manual_reset_n,
  input  wire logic              watchdog_kick_in,
  input  wire logic              margin_n,
  // device pin drive
  input  wire logic [GPIO_N-1:0] gpio_out,
  input  wire logic [GPIO_N-1:0] gpio_oe,
  // resolved pin levels
  output logic      [GPIO_N-1:0] gpio_in
);
  logic [GPIO_N-1:0] board_lvl;

  // ------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------
  // board pin levels, pin one pulled high
  assign board_lvl = {margin_n, watchdog_kick_in, manual_reset_n,
                      margin_lower_sel_n, margin_raise_sel_n, 1'b1};
  // device drive wins where enabled, else board level or pull-up
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_lvl);
endmodule

// [verification/tb_fom_pin_logic.sv]
`timescale 1ns/1ps
module tb_fom_pin_logic;
  import fom_pkg::*;
  localparam int RST_SIM = 8;
  localparam int LIMIT   = 20000;
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, seed, rd, r1, r2, r3, r4;
  logic [MON_N-1:0]  ov, uv, ew, trim;
  logic              pu_evt, wd_exp, fa, fb, af_n, rst_n, pu_flag;
  logic              log_st, m_act, kick_lvl, err, raise_n, lower_n;
  logic              mr_n, kick, marg_n;
  logic [1:0]        bank;
  logic [GPIO_N-1:0] g_in, g_out, g_oe;
  int                failures = 0;
  int                comparisons = 0;
  int                cyc = 0;
  int                logs = 0;
  int                n;

  always #20 pclk = ~pclk;

  fom_pin_logic #(.RST_CYC(RST_SIM), .AW(12)) u_fom_pin_logic (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ov_viol(ov), .uv_viol(uv),
    .ew_viol(ew), .pu_fault_evt(pu_evt), .wd_expired(wd_exp),
    .gpio_in(g_in), .gpio_out(g_out), .gpio_oe(g_oe), .fault_out_a(fa),
    .fault_out_b(fb), .any_fault_n(af_n), .reset_out_n(rst_n),
    .powerup_fault_flag(pu_flag), .fault_log_store(log_st),
    .margin_active(m_act), .dac_bank_sel(bank), .trim_dac_output(trim),
    .wd_kick_level(kick_lvl));

  fom_board_model u_fom_board_model (
    .margin_raise_sel_n(raise_n), .margin_lower_sel_n(lower_n),
    .manual_reset_n(mr_n), .watchdog_kick_in(kick), .margin_n(marg_n),
    .gpio_out(g_out), .gpio_oe(g_oe), .gpio_in(g_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic fexp(input logic [7:0] lo, input logic [7:0] hi,
                                input logic [11:0] o, input logic [11:0] u,
                                input logic [11:0] e);
    logic hit;
    hit = |({hi[3:0], lo} & ((o & {12{hi[B_OV]}}) | (u & {12{hi[B_UV]}})
                             | (e & {12{hi[B_EW]}})));
    return hit ~^ hi[B_POL];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fcase(input logic [7:0] la, input logic [7:0] ha,
                       input logic [7:0] lb, input logic [7:0] hb,
                       input logic [11:0] o, input logic [11:0] u,
                       input logic [11:0] e);
    apb(1'b1, IDX_FA_LO, la);
    apb(1'b1, IDX_FA_HI, ha);
    apb(1'b1, IDX_FB_LO, lb);
    apb(1'b1, IDX_FB_HI, hb);
    ov <= o;
    uv <= u;
    ew <= e;
    wt(3);
    chk(fa, fexp(la, ha, o, u, e));
    chk(fb, fexp(lb, hb, o, u, e));
    chk(af_n, ~|(o | u | e));
  endtask

  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (log_st === 1'b1) logs <= logs + 1;
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, pu_evt, wd_exp} = 6'h00;
    {raise_n, lower_n, mr_n, kick, marg_n} = 5'h1F;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {ov, uv, ew} = 36'h000000000;
    seed = 32'h00000026;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    chk(fa, 1'b1);
    chk(fb, 1'b1);
    chk(kick_lvl, 1'b0);
    for (logic [9:0] k = IDX_FA_LO; k <= IDX_FB_HI; k++) begin
      apb(1'b0, k, 8'h00);
      chk(rd, 32'h00000000);
    end
    apb(1'b0, 10'h040, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    $display("test reset done");
    fcase(8'h00, 8'hF0, 8'hFF, 8'h8F, 12'hFFF, 12'hFFF, 12'hFFF);
    fcase(8'h00, 8'hD8, 8'h80, 8'h20, 12'h000, 12'h880, 12'h800);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      r1 = seed;
      seed = xs(seed);
      r2 = seed;
      seed = xs(seed);
      r3 = seed;
      seed = xs(seed);
      r4 = seed;
      fcase(r1[7:0], r1[15:8], r1[23:16], r1[31:24], r2[11:0] & r2[23:12],
            r3[11:0] & r3[23:12], r4[11:0] & r4[23:12]);
    end
    $display("test fault outputs done");
    fcase(8'hFF, 8'h9F, 8'hFF, 8'h9F, 12'h000, 12'h000, 12'h000);
    // pin1 push-pull any-fault, pin2 open-drain any-fault, pin5 fault A
    apb(1'b1, IDX_CFG0, 8'h23);
    apb(1'b1, IDX_CFG1, 8'h30);
    ov <= 12'h001;
    wt(3);
    chk({g_oe[4:0], g_out[4:0]}, 10'h270);
    ov <= 12'h000;
    wt(3);
    chk({g_oe[4:0], g_out[4:0]}, 10'h221);
    apb(1'b1, IDX_CTRL, 8'h02);
    wt(2);
    chk(m_act, 1'b1);
    ov <= 12'h800;
    pu_evt <= 1'b1;
    @(posedge pclk);
    pu_evt <= 1'b0;
    wt(3);
    chk(fa, 1'b0);
    chk(af_n, 1'b1);
    chk(logs, 0);
    chk(pu_flag, 1'b0);
    apb(1'b1, IDX_CTRL, 8'h00);
    wt(3);
    chk(fb, 1'b1);
    ov <= 12'h000;
    wt(3);
    marg_n <= 1'b0;
    wt(1);
    chk(m_act, 1'b0);
    wt(3);
    chk(m_act, 1'b1);
    ov <= 12'h004;
    wt(3);
    chk(fa, 1'b0);
    marg_n <= 1'b1;
    wt(5);
    chk(fa, 1'b1);
    ov <= 12'h000;
    $display("test margin done");
    apb(1'b1, IDX_DEN_LO, 8'hA5);
    apb(1'b1, IDX_DEN_HI, 8'h03);
    apb(1'b1, IDX_CFG0, 8'hF8);
    apb(1'b1, IDX_CFG1, 8'h7F);
    for (int k = 0; k < 4; k++) begin
      raise_n <= k[0];
      lower_n <= k[1];
      wt(5);
      chk(bank, k == 2 ? BK_RAISE : (k == 1 ? BK_LOWER : BK_NORMAL));
      chk(trim, (k == 1 || k == 2) ? 12'hFFF : 12'h3A5);
    end
    {raise_n, lower_n, kick} <= 3'h6;
    wt(4);
    chk(kick_lvl, 1'b0);
    kick <= 1'b1;
    wt(4);
    chk(kick_lvl, 1'b1);
    mr_n <= 1'b0;
    wt(4);
    chk(rst_n, 1'b0);
    wt(20);
    chk(rst_n, 1'b0);
    mr_n <= 1'b1;
    n = 0;
    wt(1);
    while (rst_n !== 1'b1 && n < 100) begin
      n++;
      wt(1);
    end
    chk(n >= RST_SIM && n <= RST_SIM + 6, 1'b1);
    $display("test pin functions done");
    apb(1'b1, IDX_CFG2, 8'h03);
    wd_exp <= 1'b1;
    wt(2);
    chk({g_oe[5], g_out[5], g_in[5]}, 3'h4);
    wd_exp <= 1'b0;
    wt(2);
    chk(g_oe[5], 1'b0);
    apb(1'b1, IDX_CFG1, 8'hFF);
    // power-up event while margin is forced must be ignored
    apb(1'b1, IDX_CTRL, 8'h02);
    pu_evt <= 1'b1;
    @(posedge pclk);
    pu_evt <= 1'b0;
    wt(3);
    chk(logs, 0);
    chk(pu_flag, 1'b0);
    apb(1'b1, IDX_CTRL, 8'h00);
    pu_evt <= 1'b1;
    @(posedge pclk);
    pu_evt <= 1'b0;
    wt(3);
    chk({pu_flag, g_in[5]}, 2'h2);
    chk(logs, 1);
    apb(1'b0, IDX_STAT, 8'h00);
    chk(rd[0], 1'b1);
    apb(1'b1, IDX_STAT, 8'h01);
    wt(2);
    chk(pu_flag, 1'b0);
    $display("test watchdog and power-up done");
    complete_run();
  end
endmodule
